// ---- src/bpa_top.sv ----
// transmit and receive clocks, arbiter, cycle clocks and memory responder
`timescale 1ns/1ns
`include "bpa_defines.svh"
module bpa_top (
    input  wire logic        clock,
    input  wire logic        rst_n,
    output logic             tclk,
    output logic             rclk,
    output logic             xmit_clk,
    output logic             bus_cycle_end,
    input  wire logic        fast_shift,
    input  wire logic [1:0]  ucode_extend,
    input  wire logic        hw_stretch,
    input  wire logic        gate_left,
    input  wire logic        gate_right,
    output logic             cycle_en_n,
    output logic             cycle_clock_tick,
    output logic             tick_left,
    output logic             tick_right,
    output logic             micro_clk_tick,
    input  wire logic [3:0]  bus_req,
    output logic [3:0]       bus_grant,
    input  wire logic        cmd_adr_cycle,
    input  wire logic        data_cycle_in,
    input  wire logic [35:0] data_in,
    input  wire logic [1:0]  par_in,
    output logic [35:0]      data_out,
    output logic [1:0]       par_out,
    output logic             data_oe,
    output logic             data_cycle_out,
    output logic             bad_data_out,
    output logic             io_data_cycle_out,
    output logic             mem_busy,
    output logic             io_busy_out,
    output logic             parity_err,
    input  wire logic        mem_ready,
    input  wire logic        ecc_corr,
    input  wire logic        ecc_uncorr,
    input  wire logic [35:0] mem_rd_data,
    input  wire logic [35:0] status_rd_data,
    input  wire logic        status_done,
    input  wire logic [35:0] console_reg,
    output logic [35:0]      mem_wr_data,
    output logic             mem_wr_valid,
    output logic             status_wr_valid
);

    // ******************************
    // helpers
    // ******************************
    function automatic logic [1:0] parity2(input logic [35:0] d);
        parity2 = {^d[35:`BPA_PAR_SPLIT], ^d[`BPA_PAR_SPLIT-1:0]};
    endfunction : parity2

    function automatic bpa_pkg::bpa_cmd_t cmd_of(input logic [35:0] d);
        case (d[`BPA_CMD_HI:`BPA_CMD_LO])
            `BPA_CMD_MEM_RD: cmd_of = bpa_pkg::bpa_c_mem_rd;
            `BPA_CMD_MEM_WR: cmd_of = bpa_pkg::bpa_c_mem_wr;
            `BPA_CMD_RPW:    cmd_of = bpa_pkg::bpa_c_rpw;
            `BPA_CMD_ST_RD:  cmd_of = bpa_pkg::bpa_c_st_rd;
            `BPA_CMD_ST_WR:  cmd_of = bpa_pkg::bpa_c_st_wr;
            `BPA_CMD_CON_RD: cmd_of = bpa_pkg::bpa_c_con_rd;
            default:         cmd_of = bpa_pkg::bpa_c_other;
        endcase
    endfunction : cmd_of

    // ******************************
    // transmit and receive clocks
    // ******************************
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic       tclk_reg;
    logic       rclk_reg;
    logic       t_end;

    assign t_end = (phase_reg == 2'(`BPA_TCLK_CYC - 1));
    assign phase_next = t_end ? 2'h0 : 2'(phase_reg + 2'h1);
    assign bus_cycle_end = t_end;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 2'h0;
            tclk_reg  <= 1'b0;
            rclk_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            tclk_reg  <= (phase_next < 2'(`BPA_TCLK_CYC / 2));
            rclk_reg  <= (phase_next >= 2'(`BPA_TCLK_CYC / 2));
        end
    end

    assign tclk = tclk_reg;
    assign rclk = rclk_reg;
    // driver clock: high while either tclk or rclk is high
    assign xmit_clk = tclk_reg | rclk_reg;

    // ******************************
    // processor cycle clocks
    // ******************************
    logic [2:0] pcnt_reg;
    logic [2:0] cyc_len;
    logic       cyc_last;
    logic       parity_err_reg;

    // fast shift: one period per instruction
    assign cyc_len = fast_shift ? 3'h1
                   : 3'(`BPA_MIN_PER + {1'b0, ucode_extend});
    assign cyc_last = (3'(pcnt_reg + 3'h1) >= cyc_len) && !hw_stretch
                      && !parity_err_reg;
    assign cycle_en_n = !cyc_last;
    assign cycle_clock_tick = !cycle_en_n
        && (phase_reg >= 2'(`BPA_TCLK_CYC - `BPA_TICK_CYC));
    assign tick_left  = cycle_clock_tick && gate_left;
    assign tick_right = cycle_clock_tick && gate_right;
    assign micro_clk_tick = cycle_clock_tick && !fast_shift;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_reg <= 3'h0;
        end else if (t_end) begin
            if (cyc_last) begin
                pcnt_reg <= 3'h0;
            end else if (pcnt_reg != 3'h7) begin
                pcnt_reg <= 3'(pcnt_reg + 3'h1);
            end
        end
    end

    // ******************************
    // arbiter
    // ******************************
    logic block_reg;
    logic ca_ext_reg;
    logic arb_ok;

    // memory never requests: four requesters only
    assign arb_ok = !block_reg && !mem_busy;

    always_comb begin
        bus_grant = 4'h0;
        if (arb_ok) begin
            if (bus_req[0]) begin
                bus_grant = 4'h1;
            end else if (bus_req[1]) begin
                bus_grant = 4'h2;
            end else if (bus_req[2]) begin
                bus_grant = 4'h4;
            end else if (bus_req[3]) begin
                bus_grant = 4'h8;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            block_reg  <= 1'b0;
            ca_ext_reg <= 1'b0;
        end else if (t_end) begin
            if (|bus_grant) begin
                block_reg  <= 1'b1;
                ca_ext_reg <= 1'b1;
            end else if (block_reg && ca_ext_reg && cmd_adr_cycle) begin
                block_reg  <= 1'b1;
                ca_ext_reg <= 1'b0;
            end else begin
                block_reg  <= 1'b0;
                ca_ext_reg <= 1'b0;
            end
        end
    end

    // ******************************
    // memory responder
    // ******************************
    bpa_pkg::bpa_mem_st_t mst_reg;
    bpa_pkg::bpa_cmd_t    cmd_now;
    logic [1:0]           drv_cnt_reg;
    logic                 rpw_reg;
    logic                 err_hold_reg;

    assign cmd_now = cmd_of(data_in);
    assign mem_busy = (mst_reg == bpa_pkg::bpa_m_rd_wait)
                   || (mst_reg == bpa_pkg::bpa_m_rd_drv)
                   || (mst_reg == bpa_pkg::bpa_m_wr_wait)
                   || (mst_reg == bpa_pkg::bpa_m_rpw_wr);
    assign io_busy_out = (mst_reg == bpa_pkg::bpa_m_st_busy);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mst_reg      <= bpa_pkg::bpa_m_idle;
            drv_cnt_reg  <= 2'h0;
            rpw_reg      <= 1'b0;
            err_hold_reg <= 1'b0;
        end else if (t_end) begin
            case (mst_reg)
                bpa_pkg::bpa_m_idle: begin
                    if (cmd_adr_cycle) begin
                        case (cmd_now)
                            bpa_pkg::bpa_c_mem_rd: begin
                                mst_reg <= bpa_pkg::bpa_m_rd_wait;
                                rpw_reg <= 1'b0;
                            end
                            bpa_pkg::bpa_c_rpw: begin
                                mst_reg <= bpa_pkg::bpa_m_rd_wait;
                                rpw_reg <= 1'b1;
                            end
                            bpa_pkg::bpa_c_mem_wr: begin
                                mst_reg <= bpa_pkg::bpa_m_wr_wait;
                            end
                            bpa_pkg::bpa_c_st_wr: begin
                                mst_reg <= bpa_pkg::bpa_m_st_wait;
                            end
                            // adapter i/o and interrupt queries pass
                            default: begin
                                mst_reg <= bpa_pkg::bpa_m_idle;
                            end
                        endcase
                    end
                end
                bpa_pkg::bpa_m_rd_wait: begin
                    if (mem_ready) begin
                        mst_reg      <= bpa_pkg::bpa_m_rd_drv;
                        err_hold_reg <= ecc_corr | ecc_uncorr;
                        drv_cnt_reg  <= (ecc_corr | ecc_uncorr)
                                        ? 2'(`BPA_RD_HOLD_ERR - 2'h1)
                                        : 2'(`BPA_RD_HOLD - 2'h1);
                    end
                end
                bpa_pkg::bpa_m_rd_drv: begin
                    if (drv_cnt_reg == 2'h0) begin
                        mst_reg <= rpw_reg ? bpa_pkg::bpa_m_rpw_wr
                                           : bpa_pkg::bpa_m_idle;
                    end else begin
                        drv_cnt_reg <= 2'(drv_cnt_reg - 2'h1);
                    end
                end
                bpa_pkg::bpa_m_wr_wait, bpa_pkg::bpa_m_rpw_wr: begin
                    if (data_cycle_in) begin
                        mst_reg <= bpa_pkg::bpa_m_idle;
                    end
                end
                bpa_pkg::bpa_m_st_wait: begin
                    if (data_cycle_in) begin
                        mst_reg <= bpa_pkg::bpa_m_st_busy;
                    end
                end
                bpa_pkg::bpa_m_st_busy: begin
                    if (status_done) begin
                        mst_reg <= bpa_pkg::bpa_m_idle;
                    end
                end
                default: begin
                    mst_reg <= bpa_pkg::bpa_m_idle;
                end
            endcase
        end
    end

    // ******************************
    // bus drive and write capture
    // ******************************
    logic [35:0] data_out_reg;
    logic        data_oe_reg;
    logic        data_cycle_reg;
    logic        bad_data_reg;
    logic        io_dc_reg;
    logic [35:0] wr_data_reg;
    logic        wr_valid_reg;
    logic        st_valid_reg;
    logic        idle_cmd;

    assign idle_cmd = (mst_reg == bpa_pkg::bpa_m_idle) && cmd_adr_cycle;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_out_reg   <= 36'h0;
            data_oe_reg    <= 1'b0;
            data_cycle_reg <= 1'b0;
            bad_data_reg   <= 1'b0;
            io_dc_reg      <= 1'b0;
        end else if (t_end) begin
            data_cycle_reg <= 1'b0;
            bad_data_reg   <= 1'b0;
            io_dc_reg      <= 1'b0;
            data_oe_reg    <= 1'b0;
            if (mst_reg == bpa_pkg::bpa_m_rd_wait && mem_ready) begin
                data_out_reg   <= mem_rd_data;
                data_oe_reg    <= 1'b1;
                data_cycle_reg <= 1'b1;
                bad_data_reg   <= ecc_uncorr;
            end else if (mst_reg == bpa_pkg::bpa_m_rd_drv
                         && drv_cnt_reg != 2'h0) begin
                data_oe_reg <= 1'b1;
            end else if (idle_cmd && cmd_now == bpa_pkg::bpa_c_st_rd) begin
                data_out_reg <= status_rd_data;
                data_oe_reg  <= 1'b1;
                io_dc_reg    <= 1'b1;
            end else if (idle_cmd && cmd_now == bpa_pkg::bpa_c_con_rd) begin
                data_out_reg <= console_reg;
                data_oe_reg  <= 1'b1;
                io_dc_reg    <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_data_reg  <= 36'h0;
            wr_valid_reg <= 1'b0;
            st_valid_reg <= 1'b0;
        end else begin
            wr_valid_reg <= 1'b0;
            st_valid_reg <= 1'b0;
            if (t_end && data_cycle_in) begin
                if (mst_reg == bpa_pkg::bpa_m_wr_wait
                    || mst_reg == bpa_pkg::bpa_m_rpw_wr) begin
                    wr_data_reg  <= data_in;
                    wr_valid_reg <= 1'b1;
                end else if (mst_reg == bpa_pkg::bpa_m_st_wait) begin
                    wr_data_reg  <= data_in;
                    st_valid_reg <= 1'b1;
                end
            end
        end
    end

    // stops processor cycle ticks until reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            parity_err_reg <= 1'b0;
        end else if (t_end && (cmd_adr_cycle || data_cycle_in)
                     && parity2(data_in) != par_in) begin
            parity_err_reg <= 1'b1;
        end
    end

    assign data_out          = data_out_reg;
    assign par_out           = data_oe_reg ? parity2(data_out_reg) : 2'h0;
    assign data_oe           = data_oe_reg;
    assign data_cycle_out    = data_cycle_reg;
    assign bad_data_out      = bad_data_reg;
    assign io_data_cycle_out = io_dc_reg;
    assign parity_err        = parity_err_reg;
    assign mem_wr_data       = wr_data_reg;
    assign mem_wr_valid      = wr_valid_reg;
    assign status_wr_valid   = st_valid_reg;

    // ******************************
    // checks
    // ******************************
    property p_tick_ends;
        @(posedge clock) disable iff (!rst_n)
        cycle_clock_tick |-> t_end ##1 (phase_reg == 2'h0);
    endproperty
    a_tick_ends: assert property (p_tick_ends)
        else $error("cycle tick not at end of period");

    property p_tick_low_en;
        @(posedge clock) disable iff (!rst_n)
        cycle_clock_tick |-> !cycle_en_n && !parity_err;
    endproperty
    a_tick_low_en: assert property (p_tick_low_en)
        else $error("cycle tick while enable high");

    property p_min_cycle;
        @(posedge clock) disable iff (!rst_n)
        (cycle_clock_tick && !fast_shift) |-> $past(pcnt_reg) >= 3'h1
            || pcnt_reg >= 3'h1;
    endproperty
    a_min_cycle: assert property (p_min_cycle)
        else $error("processor cycle shorter than two periods");

    property p_one_grant;
        @(posedge clock) disable iff (!rst_n)
        $onehot0(bus_grant) and (bus_req[0] && arb_ok |-> bus_grant == 4'h1);
    endproperty
    a_one_grant: assert property (p_one_grant)
        else $error("grant not single or not by priority");

    property p_no_req;
        @(posedge clock) disable iff (!rst_n)
        bus_req == 4'h0 |-> bus_grant == 4'h0;
    endproperty
    a_no_req: assert property (p_no_req)
        else $error("grant without request");

    property p_grant_block;
        @(posedge clock) disable iff (!rst_n)
        (|bus_grant && t_end) |=> (bus_grant == 4'h0) [*2];
    endproperty
    a_grant_block: assert property (p_grant_block)
        else $error("grant issued in blocked cycle");

    property p_ca_block;
        @(posedge clock) disable iff (!rst_n)
        (|bus_grant && t_end) ##2 (cmd_adr_cycle && t_end)
            |=> (bus_grant == 4'h0) [*2];
    endproperty
    a_ca_block: assert property (p_ca_block)
        else $error("no extra block after command cycle");

    property p_mem_freeze;
        @(posedge clock) disable iff (!rst_n)
        (t_end && idle_cmd && cmd_now == bpa_pkg::bpa_c_mem_rd)
            |=> mem_busy && bus_grant == 4'h0;
    endproperty
    a_mem_freeze: assert property (p_mem_freeze)
        else $error("memory read did not freeze arbiter");

    property p_rd_hold;
        @(posedge clock) disable iff (!rst_n)
        $rose(data_cycle_out) |-> data_oe [*4];
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data held under two cycles");

    property p_con_rd;
        @(posedge clock) disable iff (!rst_n)
        (t_end && idle_cmd && cmd_now == bpa_pkg::bpa_c_con_rd)
            |=> io_data_cycle_out && data_oe && data_out == $past(console_reg);
    endproperty
    a_con_rd: assert property (p_con_rd)
        else $error("console register not returned at once");

    property p_par_err;
        @(posedge clock) disable iff (!rst_n)
        (t_end && (cmd_adr_cycle || data_cycle_in)
            && parity2(data_in) != par_in) |=> parity_err
            ##1 !cycle_clock_tick;
    endproperty
    a_par_err: assert property (p_par_err)
        else $error("parity error not caught");

endmodule : bpa_top

// ---- src/bpa_defines.svh ----
// constants for backplane bus arbitration and clock timing
`ifndef BPA_DEFINES_SVH
`define BPA_DEFINES_SVH
`define BPA_CLK_NS      100
`define BPA_TCLK_NS     150
`define BPA_TCLK_CYC    ((`BPA_TCLK_NS + `BPA_CLK_NS - 1) / `BPA_CLK_NS)
`define BPA_TICK_NS     75
`define BPA_TICK_CYC    ((`BPA_TICK_NS + `BPA_CLK_NS - 1) / `BPA_CLK_NS)
`define BPA_MIN_PER     3'h2
`define BPA_RD_HOLD     2'h2
`define BPA_RD_HOLD_ERR 2'h3
`define BPA_CMD_HI      35
`define BPA_CMD_LO      32
`define BPA_PAR_SPLIT   18
`define BPA_CMD_MEM_RD  4'h0
`define BPA_CMD_MEM_WR  4'h1
`define BPA_CMD_RPW     4'h2
`define BPA_CMD_ST_RD   4'h3
`define BPA_CMD_ST_WR   4'h4
`define BPA_CMD_CON_RD  4'h5
`endif

// ---- src/bpa_pkg.sv ----
// types for backplane bus arbitration and clock timing
package bpa_pkg;
    typedef enum logic [2:0] {
        bpa_c_mem_rd, bpa_c_mem_wr, bpa_c_rpw, bpa_c_st_rd,
        bpa_c_st_wr, bpa_c_con_rd, bpa_c_other
    } bpa_cmd_t;
    typedef enum logic [2:0] {
        bpa_m_idle, bpa_m_rd_wait, bpa_m_rd_drv, bpa_m_wr_wait,
        bpa_m_rpw_wr, bpa_m_st_wait, bpa_m_st_busy
    } bpa_mem_st_t;
endpackage : bpa_pkg

// ---- verification/bpa_mem_model.sv ----
// memory array, status source and console register beside the responder
`timescale 1ns/1ns
module bpa_mem_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        mem_busy,
    input  wire logic        io_busy_out,
    input  wire logic [3:0]  lat,
    input  wire logic [1:0]  err,
    input  wire logic [35:0] word,
    output logic             mem_ready,
    output logic             ecc_corr,
    output logic             ecc_uncorr,
    output logic [35:0]      mem_rd_data,
    output logic [35:0]      status_rd_data,
    output logic             status_done,
    output logic [35:0]      console_reg
);
    logic [3:0] wait_reg;
    // clocks spent busy, lat sets prompt or slow answers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            wait_reg <= 4'h0;
        else if (!(mem_busy || io_busy_out))
            wait_reg <= 4'h0;
        else if (wait_reg != 4'hf)
            wait_reg <= wait_reg + 4'h1;
    end
    assign mem_ready = mem_busy && (wait_reg > lat);
    assign ecc_corr = mem_ready && err[0];
    assign ecc_uncorr = mem_ready && err[1];
    // array lines wander until the word is ready
    assign mem_rd_data = mem_ready ? word : ~word ^ {9{wait_reg}};
    assign status_rd_data = ~word;
    assign status_done = io_busy_out && (wait_reg > lat);
    assign console_reg = {word[17:0], word[35:18]};
endmodule : bpa_mem_model

// ---- verification/backplane_bus_arbitration_timing_tb.sv ----
// self-checking bench for the arbiter, clocks and memory responder
`timescale 1ns/1ns
`define chk(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
fails++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module backplane_bus_arbitration_timing_tb;
    typedef struct {logic [35:0] d; logic bad; int hold;} bpa_exp_t;
    logic        clock = 1'b0, rst_n = 1'b0, fast_shift = 1'b0;
    logic        hw_stretch = 1'b0, gate_left = 1'b0, gate_right = 1'b0;
    logic        cmd_adr_cycle = 1'b0, data_cycle_in = 1'b0;
    logic [1:0]  ucode_extend = 2'h0, par_in = 2'h0, err = 2'h0, par_out;
    logic [3:0]  bus_req = 4'h0, lat = 4'h0, bus_grant;
    logic [35:0] data_in = 36'h0, word = 36'h0, data_out, mem_wr_data;
    logic [35:0] mem_rd_data, status_rd_data, console_reg;
    logic        tclk, rclk, xmit_clk, bus_cycle_end, cycle_en_n;
    logic        cycle_clock_tick, tick_left, tick_right, micro_clk_tick;
    logic        data_oe, data_cycle_out, bad_data_out, io_data_cycle_out;
    logic        mem_busy, io_busy_out, parity_err, mem_ready, ecc_corr;
    logic        ecc_uncorr, status_done, mem_wr_valid, status_wr_valid;
    logic [31:0] rr;
    logic [63:0] r;
    logic        r_prev = 1'b0, t_on = 1'b0;
    integer      seed = 32'hee50c295;
    int          fails = 0, samples_checked = 0, run = 0;
    bpa_exp_t    q[$];
    bpa_exp_t    cur;

    bpa_top bpa_top_i (.clock, .rst_n, .tclk, .rclk, .xmit_clk,
        .bus_cycle_end, .fast_shift, .ucode_extend, .hw_stretch, .gate_left,
        .gate_right, .cycle_en_n, .cycle_clock_tick, .tick_left, .tick_right,
        .micro_clk_tick, .bus_req, .bus_grant, .cmd_adr_cycle, .data_cycle_in,
        .data_in, .par_in, .data_out, .par_out, .data_oe, .data_cycle_out,
        .bad_data_out, .io_data_cycle_out, .mem_busy, .io_busy_out,
        .parity_err, .mem_ready, .ecc_corr, .ecc_uncorr, .mem_rd_data,
        .status_rd_data, .status_done, .console_reg, .mem_wr_data,
        .mem_wr_valid, .status_wr_valid);
    bpa_mem_model bpa_mem_model_i (.clock, .rst_n, .mem_busy, .io_busy_out,
        .lat, .err, .word, .mem_ready, .ecc_corr, .ecc_uncorr, .mem_rd_data,
        .status_rd_data, .status_done, .console_reg);

    always #50 clock = ~clock;
    always @(posedge clock) begin
        rr = $random(seed);
        {fast_shift, hw_stretch, gate_left, gate_right} <= rr[3:0];
        ucode_extend <= rr[5:4];
    end

    function automatic logic [1:0] par(input logic [35:0] d);
        return {^d[35:18], ^d[17:0]};
    endfunction : par

    // ************************************************************
    // watcher: takes the oldest note when a result shows
    // ************************************************************
    always @(negedge clock) begin
        if (cycle_clock_tick === 1'b1) begin
            `chk("tick_left", gate_left, tick_left)
            `chk("tick_right", gate_right, tick_right)
            `chk("micro_clk", !fast_shift, micro_clk_tick)
            `chk("cycle_en_n", 1'b0, cycle_en_n)
        end
        `chk("xmit_clk", tclk | rclk, xmit_clk)
        if (t_on) begin
            `chk("rclk", ~r_prev, rclk)
            `chk("tclk", ~rclk, tclk)
            `chk("cycle_end", rclk, bus_cycle_end)
        end
        r_prev = rclk;
        t_on = (rst_n === 1'b1);
        if (mem_busy === 1'b1) `chk("frozen", 4'h0, bus_grant)
        if (data_oe === 1'b1) begin
            run++;
            `chk("par_out", par(data_out), par_out)
        end else if (run > 0) begin
            `chk("hold", cur.hold, run)
            run = 0;
        end
        if (bus_cycle_end === 1'b1
            && (data_cycle_out | io_data_cycle_out)) begin
            cur = q.pop_front();
            `chk("data_out", cur.d, data_out)
            `chk("bad_data", cur.bad, bad_data_out)
            `chk("io_cycle", cur.hold == 2, io_data_cycle_out)
        end
        if ((mem_wr_valid | status_wr_valid) === 1'b1) begin
            cur = q.pop_front();
            `chk("mem_wr_data", cur.d, mem_wr_data)
            `chk("st_wr", cur.hold == 1, status_wr_valid)
        end
    end

    // ************************************************************
    // masters
    // ************************************************************
    task automatic bend;
        do @(negedge clock); while (bus_cycle_end !== 1'b1);
        @(posedge clock);
    endtask : bend

    task automatic get_bus(input int who, input logic [3:0] other);
        int n;
        n = 0;
        @(posedge clock);
        bus_req[who] <= 1'b1;
        do @(negedge clock);
        while (!(bus_cycle_end && bus_grant[who]) && ++n < 400);
        if (n >= 400) fails++;
        @(posedge clock);
        bus_req <= other;
    endtask : get_bus

    task automatic send(input logic c, input logic [35:0] w, input logic b);
        cmd_adr_cycle <= c;
        data_cycle_in <= !c;
        data_in <= w;
        par_in <= par(w) ^ {2{b}};
        bend;
    endtask : send

    task automatic idle;
        cmd_adr_cycle <= 1'b0;
        data_cycle_in <= 1'b0;
        data_in <= ~data_in;
        par_in <= ~par_in;
    endtask : idle

    task automatic arb_round(input logic [3:0] pat, input logic use_cmd);
        logic [3:0] left;
        int         gap;
        left = pat;
        gap = 0;
        @(posedge clock);
        bus_req <= pat;
        while (left != 4'h0 && gap < 50) begin
            @(negedge clock);
            if (bus_cycle_end) gap++;
            if (bus_cycle_end && bus_grant != 4'h0) begin
                `chk("grant", left & (~left + 4'h1), bus_grant)
                if (left != pat)
                    `chk("gap", use_cmd ? 3 : 2, gap)
                left = left & (left - 4'h1);
                @(posedge clock);
                bus_req <= left;
                gap = 0;
                if (use_cmd) begin
                    send(1'b1, 36'hf00000000, 1'b0);
                    idle;
                    gap = 1;
                end
            end
        end
        if (left != 4'h0) fails++;
        repeat (4) @(negedge clock)
            `chk("idle", 4'h0, bus_grant)
    endtask : arb_round

    task automatic mem_op(input logic [3:0] c, input logic [1:0] e);
        logic [35:0] wd;
        int          n;
        r = {$random(seed), $random(seed)};
        wd = r[35:0];
        @(posedge clock);
        err <= e;
        lat <= (c == 4'h4) ? 4'h7 : r[39:36] & 4'h7;
        word <= ~wd;
        if (c == 4'h0 || c == 4'h2) q.push_back('{~wd, e[1], e != 2'h0 ? 6 : 4});
        if (c == 4'h1 || c == 4'h2 || c == 4'h4)
            q.push_back('{wd, 1'b0, (c == 4'h4) ? 1 : 0});
        if (c == 4'h3) q.push_back('{wd, 1'b0, 2});
        if (c == 4'h5) q.push_back('{{~wd[17:0], ~wd[35:18]}, 1'b0, 2});
        get_bus((c == 4'h1) ? 1 : (c < 4'h3) ? 2 : 3, (c < 4'h3) ? 4'h8 : 4'h0);
        send(1'b1, {c, r[63:32]}, 1'b0);
        if (c == 4'h1 || c == 4'h4) send(1'b0, wd, 1'b0);
        if (c == 4'h2) begin
            idle;
            n = 0;
            do @(negedge clock); while (data_oe !== 1'b1 && ++n < 99);
            do @(negedge clock); while (data_oe !== 1'b0 && ++n < 99);
            if (n >= 99) fails++;
            `chk("rpw_busy", 1'b1, mem_busy)
            bend;
            send(1'b0, wd, 1'b0);
        end
        idle;
        if (c == 4'h4) begin
            repeat (2) @(negedge clock);
            `chk("io_busy", 1'b1, io_busy_out)
        end
        n = 0;
        do @(negedge clock);
        while ((mem_busy | io_busy_out | data_oe) !== 1'b0 && ++n < 200);
        if (n >= 200) fails++;
        @(posedge clock);
        `chk("answered", 0, q.size())
        if (c < 4'h3) get_bus(3, 4'h0);
    endtask : mem_op

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        #3000000;
        fails++;
        $display("watchdog expired");
        results;
    end

    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            r = {$random(seed), $random(seed)};
            arb_round((r[3:0] == 4'h0) ? 4'hf : r[3:0], r[4]);
        end
        $display("arbitration test done");
        for (int c = 0; c < 6; c++)
            for (int e = 0; e < 3; e++)
                if (c == 0 || e == 0) mem_op(c[3:0], e[1:0]);
        `chk("parity_ok", 1'b0, parity_err)
        $display("memory test done");
        get_bus(0, 4'h0);
        send(1'b1, 36'hf00000000, 1'b1);
        idle;
        repeat (4) @(negedge clock);
        `chk("parity_err", 1'b1, parity_err)
        repeat (20) @(negedge clock)
            `chk("stopped", 1'b0, cycle_clock_tick)
        $display("parity test done");
        results;
    end
endmodule : backplane_bus_arbitration_timing_tb
